/* rtl/fault_flags_pkg.sv */
// Constants, carriers and helper functions for the fault flag block.
// Assumes a 32-bit classic Wishbone slave and 16-bit registers in the low lanes, except the clear register, which uses all four lanes.
package fault_flags_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int REG_W = 16;
    localparam int NFLT = 8;
    localparam int SYNC_W = 16;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index
    localparam logic [ADR_W-1:0] IDX_SUPPLY_EN = 8'h08;
    localparam logic [ADR_W-1:0] IDX_BOOST_EN = 8'h0A;
    localparam logic [ADR_W-1:0] IDX_SUPPLY_FLAGS = 8'h0E;
    localparam logic [ADR_W-1:0] IDX_BOOST_FLAGS = 8'h10;
    localparam logic [ADR_W-1:0] IDX_FAULT_CLEAR = 8'h14;

    ////////////////////////////////////////////////////////////////////////
    // Field codes and reset values
    localparam logic [1:0] EN_WR_ON = 2'h3;
    localparam logic [1:0] EN_WR_OFF = 2'h1;
    localparam logic [REG_W-1:0] FLAGS_RESET = 16'h0000;
    localparam logic [REG_W-1:0] SUPPLY_EN_RESET = 16'hAAAA;
    localparam logic [REG_W-1:0] BOOST_EN_RESET = 16'hA028;
    // Even positions: clear bits and the low half of enable fields
    localparam logic [REG_W-1:0] CLR_POS = 16'h5555;
    // Lowest boost pair has no enable field
    localparam logic [NFLT-1:0] BOOST_EN_MASK = 8'hFE;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_t;

    // Supply fault detectors, highest flag first
    typedef struct packed {
        logic checksum_error;
        logic sync_input_missing;
        logic pump_fault;
        logic pump_part_missing;
        logic input_overcurrent;
        logic regulator_undervolt;
        logic input_overvolt;
        logic input_undervolt;
    } supply_faults_t;

    // Boost fault detectors, highest flag first
    typedef struct packed {
        logic overtemp;
        logic current_resistor_short;
        logic string_resistor_missing;
        logic select_resistor_missing;
        logic freq_resistor_missing;
        logic converter_overcurrent;
        logic converter_overvolt_high;
        logic converter_overvolt_low;
    } boost_faults_t;

    ////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [NFLT-1:0] odd_bits(input logic [REG_W-1:0] x);
        logic [NFLT-1:0] r;
        r = '0;
        for (int k = 0; k < NFLT; k++) r[k] = x[2*k+1];
        return r;
    endfunction : odd_bits

    function automatic logic [NFLT-1:0] even_bits(input logic [REG_W-1:0] x);
        logic [NFLT-1:0] r;
        r = '0;
        for (int k = 0; k < NFLT; k++) r[k] = x[2*k];
        return r;
    endfunction : even_bits

    // Place bit k at position 2k+1, even positions read zero
    function automatic logic [REG_W-1:0] spread(input logic [NFLT-1:0] x);
        logic [REG_W-1:0] r;
        r = '0;
        for (int k = 0; k < NFLT; k++) r[2*k+1] = x[k];
        return r;
    endfunction : spread

    // A pair clears only when flag and clear bit are both written one
    function automatic logic [NFLT-1:0] pair_clear(input logic [REG_W-1:0] w);
        return odd_bits(w) & even_bits(w);
    endfunction : pair_clear

    // Two-bit enable fields: 3h turns on, 1h turns off, others keep
    function automatic logic [NFLT-1:0] apply_enable(input logic [NFLT-1:0] old,
                                                    input logic [REG_W-1:0] w);
        logic [NFLT-1:0] r;
        r = old;
        for (int k = 0; k < NFLT; k++) begin
            if ({w[2*k+1], w[2*k]} == EN_WR_ON) r[k] = 1'b1;
            else if ({w[2*k+1], w[2*k]} == EN_WR_OFF) r[k] = 1'b0;
        end
        return r;
    endfunction : apply_enable

    // Byte address of a register index
    function automatic logic [ADR_W-1:0] reg_addr(input logic [ADR_W-1:0] idx);
        return {idx[ADR_W-3:0], 2'b00};
    endfunction : reg_addr

endpackage : fault_flags_pkg

/* rtl/fault_sync.sv */
// Two-stage synchroniser for the raw fault detector levels.
// Assumes the detectors are asynchronous levels held for at least two clocks.
`timescale 1ns/1ps
`default_nettype none
module fault_sync import fault_flags_pkg::*; (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic [SYNC_W-1:0] D,
    output logic [SYNC_W-1:0] Q
);

    // First stage, read only by the second stage
    logic [SYNC_W-1:0] meta;

    ////////////////////////////////////////////////////////////////////////
    // Both stages freeze with the clock enable
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            meta <= '0;
            Q <= '0;
        end else if (CE) begin
            meta <= D;
            Q <= meta;
        end
    end

endmodule : fault_sync
`default_nettype wire

/* rtl/fault_status_flags.sv */
// Sticky supply and boost fault flags with paired clears and one interrupt.
// Assumes a classic Wishbone master on CLK and asynchronous detector levels.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module fault_status_flags import fault_flags_pkg::*; (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [DAT_W-1:0] WB_DAT_I,
    output logic [DAT_W-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire supply_faults_t SUPPLY_FAULT_DET,
    input wire boost_faults_t BOOST_FAULT_DET,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    bus_state_t state; // Bus slave state
    logic req; // Cycle and strobe both high
    logic commit; // Write takes effect this edge
    logic hit_sen; // Supply enable selected
    logic hit_ben; // Boost enable selected
    logic hit_sup; // Supply flags selected
    logic hit_bst; // Boost flags selected
    logic hit_clr; // Clear register selected
    logic [REG_W-1:0] wd16; // Lane-masked low half
    logic [DAT_W-1:0] wd32; // Lane-masked full word
    logic [DAT_W-1:0] rd_data; // Read image of selected word
    logic [SYNC_W-1:0] sync_det; // Detectors after two flops
    supply_faults_t sync_sup; // Synchronised supply detectors
    boost_faults_t sync_bst; // Synchronised boost detectors
    logic [NFLT-1:0] det_sup; // Supply set terms by flag index
    logic [NFLT-1:0] det_bst; // Boost set terms by flag index
    logic [NFLT-1:0] supply_flags; // Recorded supply faults
    logic [NFLT-1:0] boost_flags; // Recorded boost faults
    logic [NFLT-1:0] sup_clr; // Supply flags cleared this edge
    logic [NFLT-1:0] bst_clr; // Boost flags cleared this edge
    logic [NFLT-1:0] next_supply; // Supply flags after this edge
    logic [NFLT-1:0] next_boost; // Boost flags after this edge
    logic [NFLT-1:0] supply_en; // Supply interrupt enables
    logic [NFLT-1:0] boost_en; // Boost interrupt enables
    logic [NFLT-1:0] next_supply_en; // Supply enables after this edge
    logic [NFLT-1:0] next_boost_en; // Boost enables after this edge
    logic [REG_W-1:0] sup_view; // Supply flags as read
    logic [REG_W-1:0] bst_view; // Boost flags as read

    ////////////////////////////////////////////////////////////////////////
    // Detector synchronisation
    // Detectors are analog comparators outside this clock domain
    fault_sync u_sync (
        .CLK(CLK),
        .RSTN(RSTN),
        .CE(CE),
        .D({SUPPLY_FAULT_DET, BOOST_FAULT_DET}),
        .Q(sync_det)
    );

    assign sync_sup = supply_faults_t'(sync_det[SYNC_W-1:NFLT]);
    assign sync_bst = boost_faults_t'(sync_det[NFLT-1:0]);

    // Flag k of each group sits at register bit 2k+1
    assign det_sup = {
        sync_sup.checksum_error,
        sync_sup.sync_input_missing,
        sync_sup.pump_fault,
        sync_sup.pump_part_missing,
        sync_sup.input_overcurrent,
        sync_sup.regulator_undervolt,
        sync_sup.input_overvolt,
        sync_sup.input_undervolt
    };

    assign det_bst = {
        sync_bst.overtemp,
        sync_bst.current_resistor_short,
        sync_bst.string_resistor_missing,
        sync_bst.select_resistor_missing,
        sync_bst.freq_resistor_missing,
        sync_bst.converter_overcurrent,
        sync_bst.converter_overvolt_high,
        sync_bst.converter_overvolt_low
    };

    ////////////////////////////////////////////////////////////////////////
    // Wishbone decode
    assign req = WB_CYC_I && WB_STB_I;
    assign hit_sen = (WB_ADR_I == reg_addr(IDX_SUPPLY_EN));
    assign hit_ben = (WB_ADR_I == reg_addr(IDX_BOOST_EN));
    assign hit_sup = (WB_ADR_I == reg_addr(IDX_SUPPLY_FLAGS));
    assign hit_bst = (WB_ADR_I == reg_addr(IDX_BOOST_FLAGS));
    assign hit_clr = (WB_ADR_I == reg_addr(IDX_FAULT_CLEAR));

    // Unselected lanes write zero, which is a no-op everywhere
    assign wd16 = WB_DAT_I[REG_W-1:0] & {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    assign wd32 = WB_DAT_I & {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                              {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

    // Writes land on the edge where the master sees ack
    assign commit = CE && req && WB_WE_I && (state == BUS_ACK);

    // Ack is a decode of the state flop, high for one cycle
    assign WB_ACK_O = (state == BUS_ACK);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave state: one wait cycle, then ack
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= BUS_IDLE;
        end else if (CE) begin
            case (state)
                // Take a new request
                BUS_IDLE: begin
                    if (req) state <= BUS_ACK;
                end
                // Always drop ack after one cycle
                BUS_ACK: begin
                    state <= BUS_IDLE;
                end
                default: begin
                    state <= BUS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read image
    assign sup_view = spread(supply_flags);
    assign bst_view = spread(boost_flags);

    // Clear bits always read zero; unmapped words read zero
    always_comb begin
        rd_data = '0;
        if (hit_sup) begin
            rd_data[REG_W-1:0] = sup_view;
        end else if (hit_bst) begin
            rd_data[REG_W-1:0] = bst_view;
        end else if (hit_sen) begin
            rd_data[REG_W-1:0] = spread(supply_en);
        end else if (hit_ben) begin
            rd_data[REG_W-1:0] = spread(boost_en);
        end
    end

    // Read data is captured as ack rises and holds until the next read request
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            WB_DAT_O <= '0;
        end else if (CE && req && !WB_WE_I && (state == BUS_IDLE)) begin
            WB_DAT_O <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clear decode: pair write in the flag word, or the clear register
    always_comb begin
        sup_clr = '0;
        bst_clr = '0;
        if (commit && hit_sup) begin
            sup_clr = pair_clear(wd16);
        end
        if (commit && hit_bst) begin
            bst_clr = pair_clear(wd16);
        end
        if (commit && hit_clr) begin
            sup_clr = sup_clr | odd_bits(wd32[REG_W-1:0]);
            bst_clr = bst_clr | odd_bits(wd32[DAT_W-1:REG_W]);
        end
    end

    // set wins over a clear in the same cycle
    assign next_supply = (supply_flags & ~sup_clr) | det_sup;
    assign next_boost = (boost_flags & ~bst_clr) | det_bst;

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            supply_flags <= odd_bits(FLAGS_RESET);
            boost_flags <= odd_bits(FLAGS_RESET);
        end else if (CE) begin
            supply_flags <= next_supply;
            boost_flags <= next_boost;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enables
    // Next values feed IRQ too, so an enable write moves IRQ on its own commit edge
    always_comb begin
        next_supply_en = supply_en;
        next_boost_en = boost_en;
        if (commit && hit_sen) begin
            next_supply_en = apply_enable(supply_en, wd16);
        end
        if (commit && hit_ben) begin
            // The lowest boost pair has no enable field, so it never raises IRQ
            next_boost_en = apply_enable(boost_en, wd16) & BOOST_EN_MASK;
        end
    end

    // Enable flops follow their next values
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            supply_en <= odd_bits(SUPPLY_EN_RESET);
            boost_en <= odd_bits(BOOST_EN_RESET) & BOOST_EN_MASK;
        end else if (CE) begin
            supply_en <= next_supply_en;
            boost_en <= next_boost_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt output
    // Built from next values so it tracks the flags on the same edge
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
        end else if (CE) begin
            IRQ <= |(next_supply & next_supply_en) || |(next_boost & next_boost_en & BOOST_EN_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    chk_ack_one_cycle: assert property (CE && WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    chk_ack_after_req: assert property (CE && req && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acked in one cycle");

    chk_clear_bits_zero: assert property ((sup_view & CLR_POS) == 16'h0000)
        else $error("supply clear bit reads one");

    chk_checksum_map: assert property (CE && det_sup[7] |=> sup_view[15])
        else $error("checksum fault not at bit 15");

    chk_sync_missing_map: assert property (CE && det_sup[6] |=> sup_view[13])
        else $error("sync fault not at bit 13");

    chk_pump_map: assert property (CE && det_sup[5] |=> sup_view[11])
        else $error("pump fault not at bit 11");

    chk_pump_part_map: assert property (CE && det_sup[4] |=> sup_view[9])
        else $error("pump part fault not at bit 9");

    chk_overcurrent_map: assert property (CE && det_sup[3] |=> sup_view[7])
        else $error("overcurrent fault not at bit 7");

    chk_undervolt_map: assert property (CE && det_sup[2] |=> sup_view[5])
        else $error("regulator undervolt not at bit 5");

    chk_in_undervolt_map: assert property (CE && det_sup[0] |=> sup_view[1])
        else $error("input undervolt not at bit 1");

    chk_overvolt_map: assert property (CE && det_sup[1] |=> sup_view[3])
        else $error("overvolt fault not at bit 3");

    chk_pair_clear_drop: assert property (commit && (hit_sup || hit_bst)
        |=> ((supply_flags & $past(sup_clr) & ~$past(det_sup)) == 8'h00)
         && ((boost_flags & $past(bst_clr) & ~$past(det_bst)) == 8'h00))
        else $error("paired clear left flag set");

    chk_irq_idle_low: assert property ((supply_flags == 8'h00) && (boost_flags == 8'h00) |-> !IRQ)
        else $error("interrupt high with no flags");

    chk_boost_clear_zero: assert property ((bst_view & CLR_POS) == 16'h0000)
        else $error("boost clear bit reads one");

    chk_overtemp_map: assert property (CE && det_bst[7] |=> bst_view[15] [*2])
        else $error("overtemp not held at bit 15");

    chk_enable_read_code: assert property (WB_ACK_O && !WB_WE_I && (hit_sen || hit_ben)
        |-> (WB_DAT_O[REG_W-1:0] & CLR_POS) == 16'h0000)
        else $error("enable field reads odd code");

    chk_ovl_no_irq: assert property ((boost_flags == 8'h01) && (supply_flags == 8'h00) |-> !IRQ)
        else $error("overvolt low raised interrupt");

    chk_flag_sticky: assert property (CE && (sup_clr == 8'h00)
        |=> (supply_flags & $past(supply_flags)) == $past(supply_flags))
        else $error("supply flag dropped without clear");

    chk_irq_enabled_high: assert property ((supply_flags & supply_en) != 8'h00 |-> IRQ)
        else $error("enabled flag without interrupt");

    chk_boost_irq_high: assert property ((boost_flags & boost_en) != 8'h00 |-> IRQ)
        else $error("enabled boost flag without interrupt");

    chk_freeze_holds_flags: assert property (!CE |=> $stable(supply_flags) && $stable(boost_flags))
        else $error("flags moved with clock enable low");

    cov_pair_clear: cover property (commit && hit_sup && (sup_clr != 8'h00));

    cov_set_beats_clear: cover property (CE && ((sup_clr & det_sup) != 8'h00));

    cov_irq_rise: cover property (!IRQ ##1 IRQ);

    cov_enable_write: cover property (commit && hit_ben);

    cov_boost_clear_reg: cover property (commit && hit_clr && (bst_clr != 8'h00));

endmodule : fault_status_flags
`default_nettype wire

/* verification/wb_host_model.sv */
// Host side of the register bus: a classic Wishbone master driven by tasks.
// Assumes one clock, a slave that acks each request, and a bench-level timeout.
`timescale 1ns/1ps
`default_nettype none
module wb_host_model import fault_flags_pkg::*; (
    input wire logic CLK,
    output logic CYC,
    output logic STB,
    output logic WE,
    output logic [ADR_W-1:0] ADR,
    output logic [3:0] SEL,
    output logic [DAT_W-1:0] DAT,
    input wire logic [DAT_W-1:0] DAT_I,
    input wire logic ACK
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        CYC = 1'b0;
        STB = 1'b0;
        WE = 1'b0;
        ADR = '0;
        SEL = 4'h0;
        DAT = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One classic cycle; request held until ack is sampled, no fixed latency
    task automatic access(input logic we, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] wd,
                          output logic [DAT_W-1:0] rd);
        @(posedge CLK);
        CYC <= 1'b1;
        STB <= 1'b1;
        WE <= we;
        ADR <= adr;
        SEL <= 4'hF;
        DAT <= wd;
        @(posedge CLK);
        // Only ack or the bench timeout can end this wait
        while (ACK !== 1'b1) @(posedge CLK);
        rd = DAT_I;
        // Released lines toggle so stale values cannot be mistaken for data
        CYC <= 1'b0;
        STB <= 1'b0;
        WE <= ~we;
        ADR <= ~adr;
        DAT <= ~wd;
        @(posedge CLK);
    endtask : access
endmodule : wb_host_model
`default_nettype wire

/* verification/test_fault_status_flags.sv */
// Self-checking bench for the sticky fault flags, their enables and IRQ.
// Assumes the host model above and detector levels driven on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module test_fault_status_flags import fault_flags_pkg::*;;
    logic clk, rstn, cyc, stb, we, ack, irq; // Clock, reset, bus, interrupt
    logic ce; // Clock enable into the block
    logic [ADR_W-1:0] adr; // Byte address
    logic [3:0] sel; // Byte lanes
    logic [DAT_W-1:0] wdat, rdat; // Bus data
    logic [7:0] sup_det, bst_det; // Raw detector levels
    int fails, n_compared, cycles; // Counters

    ////////////////////////////////////////////////////////////////////////
    // Clock and instances
    initial clk = 1'b0;
    always #50 clk = ~clk;
    wb_host_model u_host (.CLK(clk), .CYC(cyc), .STB(stb), .WE(we), .ADR(adr), .SEL(sel), .DAT(wdat),
        .DAT_I(rdat), .ACK(ack));
    fault_status_flags u_dut (.CLK(clk), .RSTN(rstn), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .SUPPLY_FAULT_DET(supply_faults_t'(sup_det)), .BOOST_FAULT_DET(boost_faults_t'(bst_det)), .IRQ(irq));

    ////////////////////////////////////////////////////////////////////////
    // Compare, bus and stimulus helpers
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        u_host.access(1'b0, a, 32'h0000_0000, v);
        chk_word(what, exp, v);
    endtask : rd_chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        u_host.access(1'b1, a, d, v);
    endtask : wr
    // Hold a detector for four edges, then let the synchroniser flush
    task automatic pulse_fault(input bit boost, input int k);
        @(posedge clk);
        if (boost) bst_det[k] <= 1'b1;
        else sup_det[k] <= 1'b1;
        repeat (4) @(posedge clk);
        bst_det <= 8'h00;
        sup_det <= 8'h00;
        repeat (3) @(posedge clk);
    endtask : pulse_fault

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        rd_chk("supply flags", 8'h38, 32'h0000_0000);
        rd_chk("boost flags", 8'h40, 32'h0000_0000);
        rd_chk("supply enable", 8'h20, 32'h0000_AAAA);
        rd_chk("boost enable", 8'h28, 32'h0000_A028);
        rd_chk("unmapped", 8'h3C, 32'h0000_0000);
        chk_bit("irq idle", 1'b0, irq);
        $display("test reset done");
    endtask : t_reset

    // Every pair: set, partial writes keep it, full pair write clears it
    task automatic t_pairs(input bit boost);
        logic [31:0] e;
        logic [7:0] a;
        logic on;
        a = boost ? 8'h40 : 8'h38;
        for (int k = 0; k < 8; k++) begin
            e = 32'h1 << (2 * k + 1);
            // Boost enables from reset: fields 15:14, 13:12, 5:4, 3:2 only
            on = boost ? (k == 1 || k == 2 || k == 6 || k == 7) : 1'b1;
            pulse_fault(boost, k);
            rd_chk($sformatf("flag %0d set", k), a, e);
            chk_bit($sformatf("irq %0d", k), on, irq);
            wr(a, e >> 1);
            wr(a, e);
            rd_chk($sformatf("flag %0d kept", k), a, e);
            wr(a, e | (e >> 1));
            rd_chk($sformatf("flag %0d cleared", k), a, 32'h0000_0000);
            chk_bit($sformatf("irq %0d off", k), 1'b0, irq);
        end
        $display("test pairs %0d done", boost);
    endtask : t_pairs

    task automatic t_enable;
        // all fields written 1h turn off
        wr(8'h20, 32'h0000_5555);
        rd_chk("enables off", 8'h20, 32'h0000_0000);
        pulse_fault(1'b0, 0);
        chk_bit("irq masked", 1'b0, irq);
        // field 1:0 written 3h turns on
        wr(8'h20, 32'h0000_0003);
        rd_chk("enable one", 8'h20, 32'h0000_0002);
        chk_bit("irq unmasked", 1'b1, irq);
        wr(8'h50, 32'h0000_0002);
        rd_chk("flag via clear reg", 8'h38, 32'h0000_0000);
        chk_bit("irq cleared", 1'b0, irq);
        wr(8'h20, 32'h0000_FFFF);
        rd_chk("enables on", 8'h20, 32'h0000_AAAA);
        $display("test enable done");
    endtask : t_enable

    // Boost enable write, reserved field, and boost half of the clear register
    task automatic t_boost_regs;
        wr(8'h28, 32'h0000_0C03);
        rd_chk("boost enable set", 8'h28, 32'h0000_A828);
        pulse_fault(1'b1, 5);
        chk_bit("irq string", 1'b1, irq);
        wr(8'h50, 32'h0800_0000);
        rd_chk("boost via clear reg", 8'h40, 32'h0000_0000);
        chk_bit("irq boost cleared", 1'b0, irq);
        $display("test boost regs done");
    endtask : t_boost_regs

    // With the clock enable low a detector pulse is never sampled
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        sup_det[6] <= 1'b1;
        repeat (4) @(posedge clk);
        sup_det <= 8'h00;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        rd_chk("frozen flag", 8'h38, 32'h0000_0000);
        chk_bit("frozen irq", 1'b0, irq);
        $display("test freeze done");
    endtask : t_freeze

    // A fault still present at the clear keeps its flag
    task automatic t_set_wins;
        sup_det[3] <= 1'b1;
        repeat (5) @(posedge clk);
        wr(8'h38, 32'h0000_00C0);
        rd_chk("flag held", 8'h38, 32'h0000_0080);
        chk_bit("irq held", 1'b1, irq);
        sup_det <= 8'h00;
        repeat (3) @(posedge clk);
        wr(8'h38, 32'h0000_00C0);
        rd_chk("flag gone", 8'h38, 32'h0000_0000);
        $display("test set wins done");
    endtask : t_set_wins

    ////////////////////////////////////////////////////////////////////////
    // Closing report, reached from the main sequence or the timeout
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // Hang guard, well above the roughly 650 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            $display("[FAIL] run length expected below 6000 seen 6000");
            test_done();
        end
    end

    // Main sequence: reset for 12 cycles, then the scenarios
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        sup_det = 8'h00;
        bst_det = 8'h00;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_pairs(1'b0);
        t_pairs(1'b1);
        t_enable();
        t_boost_regs();
        t_set_wins();
        t_freeze();
        test_done();
    end
endmodule : test_fault_status_flags
`default_nettype wire
